/* rtl/sfc_flow.v */
`timescale 1ns/1ps
`include "sfc_map.vh"
// Summary of operation
// - Every received payload character that finds room is held in the buffer until the bus side takes it.
// - Hardware request/clear flow control is always active.
// - Request-to-send is asserted while the buffer is below almost-full and not throttled.
// - Request-to-send drops when the buffer reaches the almost-full level.
// - At almost-empty, request-to-send returns and XON is sent if enabled.
// - Transmission stops at once when clear-to-send drops.
// - Transmission resumes as soon as clear-to-send returns.
// - Character flow control is enabled only by switch 8 of bank two.
// - With it enabled, XOFF (19) is sent before the buffer can overflow.
// - With it enabled, XON (17) is sent when input can be accepted again.
// - A received XOFF suspends transmission until a received XON.
// - While enabled, received 19 and 17 are control codes, never payload.
// - Data-terminal-ready is asserted once the device is out of reset.
module sfc_flow (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] second_config_switch_bank_i,
  input wire cts_i,
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire bus_rd_i,
  output reg bus_valid_o,
  output reg [7:0] bus_data_o,
  input wire tx_valid_i,
  input wire [7:0] tx_data_i,
  output reg tx_ready_o,
  output reg uart_tx_valid_o,
  output reg [7:0] uart_tx_data_o,
  input wire uart_tx_ready_i,
  output reg rts_o,
  output reg dtr_o,
  output reg overflow_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [2:0] cts_sync_r;
  reg cts_ok_r;
  reg [2:0] sw_sync_r;
  reg xon_en_r;
  wire cts_ok_nxt;

  // The qualified level the pin will show after this edge; the ready logic looks ahead with it.
  assign cts_ok_nxt = (cts_sync_r[1] == cts_sync_r[2]) ? cts_sync_r[2] : cts_ok_r;

  // Pins pass three flops; a change counts when the last two agree.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cts_sync_r <= 3'h0;
      cts_ok_r <= 1'b0;
      sw_sync_r <= 3'h0;
      xon_en_r <= 1'b0;
    end else begin
      cts_sync_r <= {cts_sync_r[1:0], cts_i};
      sw_sync_r <= {sw_sync_r[1:0], second_config_switch_bank_i[`SFC_CFG_XON_BIT]};
      cts_ok_r <= cts_ok_nxt;
      if (sw_sync_r[1] == sw_sync_r[2]) begin
        xon_en_r <= sw_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flow code decoding
  // ----------------------------------------------------------------
  // Both the buffer and the peer pause logic decode the same two codes.
  function is_xoff(input [7:0] c);
    is_xoff = (c == `SFC_XOFF_CODE);
  endfunction

  function is_xon(input [7:0] c);
    is_xon = (c == `SFC_XON_CODE);
  endfunction

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  reg [7:0] wr_ptr_r;
  reg [7:0] rd_ptr_r;
  reg [8:0] count_r;
  wire [7:0] ram_q;
  wire is_ctrl;
  wire full;
  wire push;
  wire pop;
  reg pending_r;

  // Flow codes are consumed, not stored, while character control is on.
  assign is_ctrl = xon_en_r && (is_xoff(rx_data_i) || is_xon(rx_data_i));
  assign full = (count_r == `SFC_DEPTH);
  assign push = rx_valid_i && !is_ctrl && !full;
  // A pop is only issued when the output stage is free or being read.
  assign pop = (count_r != 9'h0000) && !pending_r && (!bus_valid_o || bus_rd_i);

  sfc_ram u_ram (
    .clk_i(clk_i),
    .wr_en_i(push),
    .wr_addr_i(wr_ptr_r),
    .wr_data_i(rx_data_i),
    .rd_addr_i(rd_ptr_r),
    .rd_data_o(ram_q)
  );

  // Pointers, occupancy and the registered output stage toward the bus side.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= 8'h00;
      rd_ptr_r <= 8'h00;
      count_r <= 9'h0000;
      pending_r <= 1'b0;
      bus_valid_o <= 1'b0;
      bus_data_o <= 8'h00;
      overflow_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 8'h01;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 8'h01;
      end
      count_r <= count_r + {8'h00, push} - {8'h00, pop};
      pending_r <= pop;
      // Memory data arrives one cycle after the pop address was presented.
      if (pending_r) begin
        bus_valid_o <= 1'b1;
        bus_data_o <= ram_q;
      end else if (bus_rd_i) begin
        bus_valid_o <= 1'b0;
      end
      // Sticky: a host that ignored throttling lost a character.
      if (rx_valid_i && !is_ctrl && full) begin
        overflow_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive throttle with hysteresis
  // ----------------------------------------------------------------
  reg throttled_r;
  reg xoff_req_r;
  reg xon_req_r;
  reg peer_xoff_r;
  wire send_code;
  wire thr_set;
  wire thr_clr;
  wire peer_xoff_nxt;

  // Entry and exit of the throttled state use two separate levels.
  assign thr_set = !throttled_r && (count_r >= `SFC_ALMOST_FULL);
  assign thr_clr = throttled_r && (count_r <= `SFC_ALMOST_EMPTY);
  // Peer pause state; the ready logic reads the next value so that a pause takes effect without lag.
  assign peer_xoff_nxt = !xon_en_r ? 1'b0 :
    (rx_valid_i && is_xoff(rx_data_i)) ? 1'b1 :
    (rx_valid_i && is_xon(rx_data_i)) ? 1'b0 : peer_xoff_r;

  // The almost-full margin of sixteen absorbs characters still in flight.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      throttled_r <= 1'b0;
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
      xoff_req_r <= 1'b0;
      xon_req_r <= 1'b0;
      peer_xoff_r <= 1'b0;
    end else begin
      dtr_o <= 1'b1;
      if (thr_set) begin
        throttled_r <= 1'b1;
        xoff_req_r <= xon_en_r;
        xon_req_r <= 1'b0;
      end else if (thr_clr) begin
        throttled_r <= 1'b0;
        xon_req_r <= xon_en_r;
        xoff_req_r <= 1'b0;
      end else if (send_code) begin
        xoff_req_r <= 1'b0;
        xon_req_r <= 1'b0;
      end
      // Hardware handshake stays active regardless of the switch.
      rts_o <= !throttled_r && !(count_r >= `SFC_ALMOST_FULL);
      peer_xoff_r <= peer_xoff_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  wire tx_free;
  wire data_go;
  wire code_pend_nxt;
  wire tx_busy_nxt;

  // Flow codes go out ahead of data and ignore a peer XOFF, but not CTS.
  assign tx_free = !uart_tx_valid_o || uart_tx_ready_i;
  assign send_code = (xoff_req_r || xon_req_r) && cts_ok_r && tx_free;
  assign data_go = tx_valid_i && tx_ready_o;
  // Ready is promised one cycle ahead, so it is built from next-cycle state: an accepted
  // character always finds the transmitter slot free and never collides with a flow code.
  assign code_pend_nxt = (thr_set || thr_clr) ? xon_en_r : (!send_code && (xoff_req_r || xon_req_r));
  assign tx_busy_nxt = send_code || data_go || (uart_tx_valid_o && !uart_tx_ready_i);

  // The character in the transmitter is withdrawn-free: valid only rises when clear.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uart_tx_valid_o <= 1'b0;
      uart_tx_data_o <= 8'h00;
      tx_ready_o <= 1'b0;
    end else begin
      if (send_code) begin
        uart_tx_valid_o <= 1'b1;
        uart_tx_data_o <= xoff_req_r ? `SFC_XOFF_CODE : `SFC_XON_CODE;
      end else if (data_go) begin
        uart_tx_valid_o <= 1'b1;
        uart_tx_data_o <= tx_data_i;
      end else if (uart_tx_ready_i) begin
        uart_tx_valid_o <= 1'b0;
      end
      // Stop at once on CTS loss, resume as soon as it returns.
      tx_ready_o <= cts_ok_nxt && !peer_xoff_nxt && !code_pend_nxt && !tx_busy_nxt;
    end
  end
endmodule // sfc_flow

/* rtl/sfc_map.vh */
`ifndef SFC_MAP_VH
`define SFC_MAP_VH
// ----------------------------------------------------------------
// Flow control constants
// ----------------------------------------------------------------
`define SFC_XOFF_CODE 8'h13
`define SFC_XON_CODE 8'h11
`define SFC_ADDR_W 8
`define SFC_DEPTH 9'h0100
`define SFC_ALMOST_FULL 9'h00F0
`define SFC_ALMOST_EMPTY 9'h0010
`define SFC_CFG_XON_BIT 7
`endif

/* rtl/sfc_ram.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Receive character memory
// ----------------------------------------------------------------
module sfc_ram (
  input wire clk_i,
  input wire wr_en_i,
  input wire [7:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [7:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem [0:255];

  // Write port and registered read port; no reset needed for storage.
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // sfc_ram

/* verif/sfc_flow_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module sfc_flow_chk (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] second_config_switch_bank_i,
  input wire cts_i,
  input wire tx_valid_i,
  input wire [7:0] tx_data_i,
  input wire tx_ready_o,
  input wire uart_tx_valid_o,
  input wire [7:0] uart_tx_data_o,
  input wire rts_o,
  input wire dtr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire sw = second_config_switch_bank_i[7];
  // Six low samples outlast the synchroniser and the ready register.
  sequence s_cts_low; !cts_i [*6]; endsequence
  // A character that starts with no user offer behind it is a code.
  sequence s_own; $rose(uart_tx_valid_o) && !$past(tx_valid_i && tx_ready_o); endsequence
  property p_dtr; !$past(sys_rst_i) |-> dtr_o; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr");
  property p_take; tx_valid_i && tx_ready_o |=> uart_tx_valid_o && uart_tx_data_o == $past(tx_data_i); endproperty
  a_take: assert property (p_take) else $error("take");
  property p_cts_stop; s_cts_low |-> !tx_ready_o; endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("cts ready");
  property p_cts_hold; s_cts_low ##1 !cts_i |-> !$rose(uart_tx_valid_o); endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("cts send");
  property p_own; s_own |-> sw && (uart_tx_data_o == 8'h13 || uart_tx_data_o == 8'h11); endproperty
  a_own: assert property (p_own) else $error("code");
  property p_xoff; sw && cts_i && $fell(rts_o) |-> ##[0:40] uart_tx_valid_o && uart_tx_data_o == 8'h13; endproperty
  a_xoff: assert property (p_xoff) else $error("xoff");
  property p_xon; sw && $past(dtr_o) && $rose(rts_o) |-> ##[0:40] uart_tx_valid_o && uart_tx_data_o == 8'h11; endproperty
  a_xon: assert property (p_xon) else $error("xon");
  property p_hyst; $fell(rts_o) |=> !rts_o [*8]; endproperty
  a_hyst: assert property (p_hyst) else $error("hyst");
endmodule // sfc_flow_chk
bind sfc_flow sfc_flow_chk u_chk (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .second_config_switch_bank_i(second_config_switch_bank_i),
  .cts_i(cts_i),
  .tx_valid_i(tx_valid_i),
  .tx_data_i(tx_data_i),
  .tx_ready_o(tx_ready_o),
  .uart_tx_valid_o(uart_tx_valid_o),
  .uart_tx_data_o(uart_tx_data_o),
  .rts_o(rts_o),
  .dtr_o(dtr_o)
);

/* verif/sfc_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------
module sfc_host (
  input wire clk_i,
  input wire rts_i,
  output reg rx_valid_o,
  output reg [7:0] rx_data_o,
  output reg uart_tx_ready_o
);
  // Idle levels before the first character is offered.
  initial begin
    rx_valid_o <= 1'b0;
    rx_data_o <= 8'h00;
  end
  // Random stalls give the sender both prompt and slow answers.
  always @(posedge clk_i) begin
    uart_tx_ready_o <= 1'($urandom);
  end
  // One character per call; a released data line does not keep its value.
  task send(input [7:0] c);
    begin
      do @(posedge clk_i); while (!rts_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= c;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~c;
    end
  endtask
endmodule // sfc_host

/* verif/serial_rx_buffer_flow_control_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Flow control bench
// ----------------------------------------------------------------
module serial_rx_buffer_flow_control_tb;
  reg clk_i = 1'b0;
  reg sys_rst_i;
  reg [7:0] second_config_switch_bank_i;
  reg cts_i;
  reg bus_rd_i;
  reg tx_valid_i;
  reg [7:0] tx_data_i;
  wire rx_valid_i, bus_valid_o, tx_ready_o, uart_tx_valid_o, uart_tx_ready_i, rts_o, dtr_o, overflow_o;
  wire [7:0] rx_data_i, bus_data_o, uart_tx_data_o;
  int n_fail = 0;
  int checks_done = 0;
  reg [7:0] q_bus[$];
  reg [7:0] q_tx[$];
  reg [7:0] b;
  always #2.5 clk_i = ~clk_i;
  sfc_flow DUT (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .second_config_switch_bank_i(second_config_switch_bank_i),
    .cts_i(cts_i),
    .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i),
    .bus_rd_i(bus_rd_i),
    .bus_valid_o(bus_valid_o),
    .bus_data_o(bus_data_o),
    .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o),
    .uart_tx_valid_o(uart_tx_valid_o),
    .uart_tx_data_o(uart_tx_data_o),
    .uart_tx_ready_i(uart_tx_ready_i),
    .rts_o(rts_o),
    .dtr_o(dtr_o),
    .overflow_o(overflow_o)
  );
  sfc_host host (.clk_i(clk_i), .rts_i(rts_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .uart_tx_ready_o(uart_tx_ready_i));
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Take n characters from the bus side, one handshake each.
  task rd(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (!bus_valid_o);
      bus_rd_i <= 1'b1;
      @(posedge clk_i);
      bus_rd_i <= 1'b0;
    end
  endtask
  // Offer a character that must not be taken yet.
  task stall;
    b = 8'($urandom);
    tx_data_i <= b;
    tx_valid_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("ready", tx_ready_o, 8'h00);
    q_tx.push_back(b);
  endtask
  task txw;
    do @(posedge clk_i); while (!tx_ready_o);
    tx_valid_i <= 1'b0;
  endtask
  // Each delivered character is compared with the oldest noted one.
  always @(posedge clk_i) begin
    if (bus_valid_o && bus_rd_i) chk("bus", bus_data_o, q_bus.size() ? q_bus.pop_front() : 8'hxx);
    if (uart_tx_valid_o && uart_tx_ready_i) chk("tx", uart_tx_data_o, q_tx.size() ? q_tx.pop_front() : 8'hxx);
  end
  // The whole sequence needs about 1300 cycles; this limit of 20000 cycles is far above.
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial begin
    void'($urandom(18577));
    sys_rst_i <= 1'b1;
    second_config_switch_bank_i <= 8'h80;
    cts_i <= 1'b1;
    bus_rd_i <= 1'b0;
    tx_valid_i <= 1'b0;
    tx_data_i <= 8'h00;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("dtr", dtr_o, 8'h01);
    // The first character waits in the output stage outside the count, so one more than almost-full is sent.
    for (int i = 0; i < 241; i++) begin
      b = 8'($urandom) | 8'h80;
      q_bus.push_back(b);
      host.send(b);
    end
    q_tx.push_back(8'h13);
    repeat (3) @(posedge clk_i);
    chk("rts", rts_o, 8'h00);
    rd(223);
    repeat (8) @(posedge clk_i);
    chk("rts", rts_o, 8'h00);
    q_tx.push_back(8'h11);
    rd(1);
    repeat (8) @(posedge clk_i);
    chk("rts", rts_o, 8'h01);
    rd(16);
    host.send(8'h13);
    repeat (4) @(posedge clk_i);
    stall;
    host.send(8'h11);
    txw;
    cts_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    stall;
    cts_i <= 1'b1;
    txw;
    second_config_switch_bank_i <= 8'h7F;
    repeat (8) @(posedge clk_i);
    q_bus.push_back(8'h11);
    host.send(8'h11);
    // The last payload character still sits in the output stage ahead of this one.
    rd(2);
    repeat (40) @(posedge clk_i);
    chk("left", 8'(q_bus.size() + q_tx.size()), 8'h00);
    chk("overflow", overflow_o, 8'h00);
    end_of_test;
  end
endmodule // serial_rx_buffer_flow_control_tb
